// >>> lrb_pkg.sv
// shared constants and types for the line roi and merge stage
// Operation
// - every output image is exactly one line tall; height fixed at one
// - unmerged width 128 up to 16384 minus offset, step 128
// - unmerged offset 0 up to 16384 minus width, step 128
// - merged width 64 up to 8192 minus offset, step 64
// - merged offset 0 up to 8192 minus width, step 64
// - offset counts from zero; offset 128 starts at pixel 129
// - merge mode combines each adjacent horizontal pixel pair into one
// - merge selectable between sum and average of the pair
// - colour variant offers 8, 10, 12 bit rgb; 8 bit default
// - mono variant offers 8, 10, 12 bit mono; 8 bit default
// - begin command starts line output, halt command stops it
// - with trigger enabled, output needs begin command then trigger
// - after end command, triggers are ignored and produce no output
// - line rate ceiling uses merged output width when merging
// - mono high speed option allows line rates up to 290 khz
package lrb_pkg;
  localparam int PIX_W = 12;
  localparam int CNT_W = 15;
  localparam logic [CNT_W-1:0] SENSOR_PIX = 15'h4000;
  localparam logic [CNT_W-1:0] MERGED_PIX = 15'h2000;
  localparam logic [CNT_W-1:0] STEP_FULL = 15'h0080;
  localparam logic [CNT_W-1:0] STEP_MERGED = 15'h0040;
  localparam logic [CNT_W-1:0] RST_WIDTH = 15'h4000;
  localparam logic [CNT_W-1:0] RST_OFFSET = 15'h0000;
  localparam logic [CNT_W-1:0] IMAGE_HEIGHT = 15'h0001;
  localparam int CLK_HZ = 10000000;
  localparam int BYTE_PER_PIX_8 = 1;
  localparam int BYTE_PER_PIX_HI = 2;
  localparam int NORMAL_MAX_HZ = 277000;
  localparam int FAST_MAX_HZ = 290000;
  // least line period in clocks, rounded up
  localparam int NORMAL_MIN_CLK = (CLK_HZ + NORMAL_MAX_HZ - 1) / NORMAL_MAX_HZ;
  localparam int FAST_MIN_CLK = (CLK_HZ + FAST_MAX_HZ - 1) / FAST_MAX_HZ;
  localparam logic [1:0] FMT_RST = 2'h0;
  typedef enum logic [1:0] {
    LRB_FMT8 = 2'b00,
    LRB_FMT10 = 2'b01,
    LRB_FMT12 = 2'b10
  } lrb_fmt_type;
  typedef enum logic [1:0] {
    LRB_IDLE = 2'b00,
    LRB_ARMED = 2'b01,
    LRB_RUN = 2'b10
  } lrb_state_type;
endpackage : lrb_pkg

// >>> lrb_pair_if.sv
// carries the pixel pair stream between the top and the merge unit
`timescale 1ns/10ps
interface lrb_pair_if;
  import lrb_pkg::*;
  logic in_valid;
  logic [PIX_W-1:0] in_pix;
  logic merge_en;
  logic avg_mode;
  logic out_valid;
  logic [PIX_W-1:0] out_pix;
  logic line_clear;
  modport src (output in_valid, in_pix, merge_en, avg_mode, line_clear,
               input out_valid, out_pix);
  modport unit (input in_valid, in_pix, merge_en, avg_mode, line_clear,
                output out_valid, out_pix);
endinterface : lrb_pair_if

// >>> lrb_merge.sv
// horizontal pair merge: sum or average, or pass-through
`timescale 1ns/10ps
module lrb_merge
  import lrb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pixel stream
  lrb_pair_if.unit pif
);
  logic half_ff;
  logic [PIX_W-1:0] first_ff;
  logic out_valid_ff;
  logic [PIX_W-1:0] out_pix_ff;
  logic [PIX_W:0] pair_sum;
  logic [PIX_W-1:0] merged;
  assign pair_sum = {1'b0, first_ff} + {1'b0, pif.in_pix};
  // sum saturates so a bright pair never wraps to dark
  assign merged = pif.avg_mode ? pair_sum[PIX_W:1] :
                  (pair_sum[PIX_W] ? {PIX_W{1'b1}} : pair_sum[PIX_W-1:0]);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      half_ff <= 1'b0;
      first_ff <= '0;
      out_valid_ff <= 1'b0;
      out_pix_ff <= '0;
    end else begin
      out_valid_ff <= 1'b0;
      if (pif.line_clear) begin
        half_ff <= 1'b0;
      end else if (pif.in_valid) begin
        if (!pif.merge_en) begin
          out_valid_ff <= 1'b1;
          out_pix_ff <= pif.in_pix;
        end else if (!half_ff) begin
          half_ff <= 1'b1;
          first_ff <= pif.in_pix;
        end else begin
          half_ff <= 1'b0;
          out_valid_ff <= 1'b1;
          out_pix_ff <= merged;
        end
      end
    end
  end
  assign pif.out_valid = out_valid_ff;
  assign pif.out_pix = out_pix_ff;
  a_pair_timing: assert property (@(posedge clk) disable iff (reset)
    (pif.in_valid && pif.merge_en && half_ff && !pif.line_clear)
    |=> pif.out_valid)
    else $error("merged pixel missing after second of pair");
  a_avg_value: assert property (@(posedge clk) disable iff (reset)
    (pif.in_valid && pif.merge_en && half_ff && pif.avg_mode
     && !pif.line_clear)
    |=> pif.out_pix == $past(pair_sum[PIX_W:1]))
    else $error("average of pair wrong");
endmodule : lrb_merge

// >>> lrb_line_roi.sv
// line region crop, pixel pair merge, sample format and capture gating
`timescale 1ns/10ps
module lrb_line_roi
  import lrb_pkg::*;
#(
  parameter bit COLOUR = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // settings
  input wire logic cfg_write,
  input wire logic [CNT_W-1:0] cfg_width,
  input wire logic [CNT_W-1:0] horizontal_start_offset,
  input wire logic horizontal_pixel_merge,
  input wire logic merge_average,
  input wire logic [1:0] sample_format_select,
  input wire logic external_trigger_enable,
  input wire logic line_rate_speed_option,
  // capture commands, one-cycle pulses; trigger pin is a level, synchronised and edge-detected
  input wire logic capture_begin_cmd,
  input wire logic capture_halt_cmd,
  input wire logic capture_end_cmd,
  input wire logic acq_trigger_pin,
  // sensor line readout
  input wire logic sensor_line_start,
  input wire logic sensor_valid,
  input wire logic [PIX_W-1:0] sensor_pix,
  // image stream
  output logic img_valid,
  output logic [PIX_W-1:0] img_data,
  output logic img_line_start,
  output logic img_line_end,
  // status
  output logic [CNT_W-1:0] active_width,
  output logic [CNT_W-1:0] active_offset,
  output logic [CNT_W-1:0] image_height,
  output logic cfg_rejected,
  output logic capturing,
  output logic [CNT_W-1:0] min_line_clocks
);
  lrb_state_type state_ff, nxt_state;
  logic [CNT_W-1:0] width_ff, offset_ff;
  logic merge_ff, avg_ff;
  lrb_fmt_type fmt_ff;
  logic rej_ff;
  logic trig_s1_ff, trig_s2_ff, trig_s3_ff;
  logic [CNT_W-1:0] pos_ff;
  logic [CNT_W-1:0] sent_ff;
  logic in_line_ff;
  logic valid_ff, ls_ff, le_ff;
  logic [PIX_W-1:0] data_ff;
  logic [CNT_W-1:0] minclk_ff;
  // capture status from a flop, loaded with the state
  logic run_ff;
  logic [CNT_W-1:0] height_ff;
  logic [CNT_W:0] line_bytes;
  logic [CNT_W-1:0] rate_floor, nxt_minclk;
  logic trig_rise, cfg_ok, in_roi, run, take_pix;
  logic [CNT_W-1:0] lim, stp, nxt_pos, nxt_sent;
  logic [CNT_W:0] span;
  logic [PIX_W-1:0] fmt_pix;
  lrb_pair_if pif ();

  // true when width and offset fit limits and steps for this merge mode
  function automatic logic roi_legal(input logic [CNT_W-1:0] w,
                                     input logic [CNT_W-1:0] o,
                                     input logic m);
    logic [CNT_W-1:0] l;
    logic [CNT_W-1:0] s;
    logic [CNT_W:0] e;
    l = m ? MERGED_PIX : SENSOR_PIX;
    s = m ? STEP_MERGED : STEP_FULL;
    e = {1'b0, w} + {1'b0, o};
    roi_legal = (w >= s) && ((w & (s - 15'h0001)) == 15'h0000) &&
                ((o & (s - 15'h0001)) == 15'h0000) && (e <= {1'b0, l});
  endfunction : roi_legal

  assign lim = merge_ff ? MERGED_PIX : SENSOR_PIX;
  assign stp = merge_ff ? STEP_MERGED : STEP_FULL;
  assign cfg_ok = roi_legal(cfg_width, horizontal_start_offset,
                            horizontal_pixel_merge);
  assign trig_rise = trig_s2_ff && !trig_s3_ff;
  assign run = (state_ff == LRB_RUN);

  // capture gating
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LRB_IDLE: begin
        if (capture_begin_cmd) begin
          nxt_state = external_trigger_enable ? LRB_ARMED : LRB_RUN;
        end
      end
      LRB_ARMED: begin
        if (capture_halt_cmd || capture_end_cmd) begin
          nxt_state = LRB_IDLE;
        end else if (trig_rise) begin
          nxt_state = LRB_RUN;
        end
      end
      LRB_RUN: begin
        if (capture_halt_cmd || capture_end_cmd) begin
          nxt_state = LRB_IDLE;
        end
      end
      default: nxt_state = LRB_IDLE;
    endcase
  end

  // crop position counts merged units when merging
  assign pif.in_valid = sensor_valid && in_line_ff;
  assign pif.in_pix = sensor_pix;
  assign pif.merge_en = merge_ff;
  assign pif.avg_mode = avg_ff;
  assign pif.line_clear = sensor_line_start;
  assign span = {1'b0, offset_ff} + {1'b0, width_ff};
  assign in_roi = ({1'b0, pos_ff} >= {1'b0, offset_ff}) &&
                  ({1'b0, pos_ff} < span);
  assign take_pix = pif.out_valid && in_roi && run;
  assign nxt_pos = pif.out_valid ? pos_ff + 15'h0001 : pos_ff;
  assign nxt_sent = take_pix ? sent_ff + 15'h0001 : sent_ff;

  // format after crop; low bits of the 12-bit sample are dropped
  assign fmt_pix = (fmt_ff == LRB_FMT8) ? {4'h0, pif.out_pix[11:4]} :
                   (fmt_ff == LRB_FMT10) ? {2'h0, pif.out_pix[11:2]} :
                   pif.out_pix;

  lrb_merge u_merge (
    .clk(clk),
    .reset(reset),
    .pif(pif)
  );

  // two flops against metastability; the third only finds the edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trig_s1_ff <= 1'b0;
      trig_s2_ff <= 1'b0;
      trig_s3_ff <= 1'b0;
    end else begin
      trig_s1_ff <= acq_trigger_pin;
      trig_s2_ff <= trig_s1_ff;
      trig_s3_ff <= trig_s2_ff;
    end
  end

  // settings change only between lines, never mid-line
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      width_ff <= RST_WIDTH;
      offset_ff <= RST_OFFSET;
      merge_ff <= 1'b0;
      avg_ff <= 1'b0;
      fmt_ff <= lrb_fmt_type'(FMT_RST);
      rej_ff <= 1'b0;
    end else if (cfg_write && !in_line_ff) begin
      rej_ff <= !cfg_ok;
      avg_ff <= merge_average;
      if (sample_format_select != 2'b11) begin
        fmt_ff <= lrb_fmt_type'(sample_format_select);
      end
      if (cfg_ok) begin
        width_ff <= cfg_width;
        offset_ff <= horizontal_start_offset;
        merge_ff <= horizontal_pixel_merge;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff <= LRB_IDLE;
      run_ff <= 1'b0;
      height_ff <= IMAGE_HEIGHT;
      pos_ff <= '0;
      sent_ff <= '0;
      in_line_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // begin mid-line gives a partial line; start between lines
      run_ff <= (nxt_state == LRB_RUN);
      height_ff <= IMAGE_HEIGHT;
      if (sensor_line_start) begin
        pos_ff <= '0;
        sent_ff <= '0;
        in_line_ff <= 1'b1;
      end else begin
        pos_ff <= nxt_pos;
        sent_ff <= nxt_sent;
        if (pif.out_valid && ({1'b0, nxt_pos} >= {1'b0, lim})) begin
          in_line_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid_ff <= 1'b0;
      data_ff <= '0;
      ls_ff <= 1'b0;
      le_ff <= 1'b0;
    end else begin
      valid_ff <= take_pix;
      data_ff <= take_pix ? fmt_pix : data_ff;
      ls_ff <= take_pix && (sent_ff == 15'h0000);
      le_ff <= take_pix && (nxt_sent == width_ff);
    end
  end

  // least line period grows with merged width and bytes per pixel
  assign line_bytes = (fmt_ff == LRB_FMT8) ?
    (CNT_W+1)'({1'b0, width_ff} * BYTE_PER_PIX_8) :
    (CNT_W+1)'({1'b0, width_ff} * BYTE_PER_PIX_HI);
  assign rate_floor = (!COLOUR && line_rate_speed_option) ?
    CNT_W'(FAST_MIN_CLK) : CNT_W'(NORMAL_MIN_CLK);
  // a full line at two bytes per pixel overflows the field, so saturate
  assign nxt_minclk = line_bytes[CNT_W] ? {CNT_W{1'b1}} :
    (line_bytes[CNT_W-1:0] < rate_floor) ? rate_floor :
    line_bytes[CNT_W-1:0];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      minclk_ff <= '0;
    end else begin
      minclk_ff <= nxt_minclk;
    end
  end

  assign img_valid = valid_ff;
  assign img_data = data_ff;
  assign img_line_start = ls_ff;
  assign img_line_end = le_ff;
  assign active_width = width_ff;
  assign active_offset = offset_ff;
  assign image_height = height_ff;
  assign cfg_rejected = rej_ff;
  assign capturing = run_ff;
  assign min_line_clocks = minclk_ff;

  sequence s_armed_trig;
    state_ff == LRB_ARMED && trig_rise && !capture_halt_cmd
      && !capture_end_cmd;
  endsequence
  sequence s_stop_cmd;
    state_ff != LRB_IDLE && (capture_halt_cmd || capture_end_cmd);
  endsequence
  a_trig_starts: assert property (@(posedge clk) disable iff (reset)
    s_armed_trig |=> run)
    else $error("trigger while armed did not start output");
  a_no_out_idle: assert property (@(posedge clk) disable iff (reset)
    !run |=> !img_valid)
    else $error("pixel output while not capturing");
  a_end_stops: assert property (@(posedge clk) disable iff (reset)
    capture_end_cmd |=> !run ##1 !img_valid)
    else $error("output continued after end command");
  a_begin_free: assert property (@(posedge clk) disable iff (reset)
    (state_ff == LRB_IDLE && capture_begin_cmd && !external_trigger_enable)
    |=> run)
    else $error("begin command did not start free output");
  a_begin_armed: assert property (@(posedge clk) disable iff (reset)
    (state_ff == LRB_IDLE && capture_begin_cmd && external_trigger_enable)
    |=> state_ff == LRB_ARMED)
    else $error("begin with trigger enabled did not arm");
  a_roi_legal: assert property (@(posedge clk) disable iff (reset)
    roi_legal(width_ff, offset_ff, merge_ff))
    else $error("applied region breaks limits");
  a_bad_rejected: assert property (@(posedge clk) disable iff (reset)
    (cfg_write && !in_line_ff && !cfg_ok) |=> cfg_rejected
      && $stable(width_ff))
    else $error("illegal region was applied");
  a_line_count: assert property (@(posedge clk) disable iff (reset)
    img_line_end |-> ($past(sent_ff) + 15'h0001) == width_ff)
    else $error("line end after wrong pixel count");
  a_fmt8_range: assert property (@(posedge clk) disable iff (reset)
    (img_valid && fmt_ff == LRB_FMT8) |-> img_data[11:8] == 4'h0)
    else $error("8-bit sample wider than 8 bits");
  a_halt_stops: assert property (@(posedge clk) disable iff (reset)
    s_stop_cmd |=> !capturing)
    else $error("stop command did not end output");
  a_idle_trig: assert property (@(posedge clk) disable iff (reset)
    (state_ff == LRB_IDLE && !capture_begin_cmd) |=> !capturing)
    else $error("output started while idle");
  a_arm_hold: assert property (@(posedge clk) disable iff (reset)
    (state_ff == LRB_ARMED && !trig_rise) |=> !capturing)
    else $error("armed capture started without trigger");
  // region may only move between lines
  a_cfg_frozen: assert property (@(posedge clk) disable iff (reset)
    in_line_ff |=> $stable(width_ff) && $stable(offset_ff))
    else $error("region changed during a line");
  a_pos_reset: assert property (@(posedge clk) disable iff (reset)
    sensor_line_start |=> pos_ff == 15'h0000)
    else $error("line position not cleared at line start");
  a_fmt10_range: assert property (@(posedge clk) disable iff (reset)
    (img_valid && fmt_ff == LRB_FMT10) |-> img_data[11:10] == 2'h0)
    else $error("10-bit sample wider than 10 bits");
  a_rate_floor: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> min_line_clocks >= $past(rate_floor))
    else $error("least line period below its floor");
  a_strobe_valid: assert property (@(posedge clk) disable iff (reset)
    (img_line_start || img_line_end) |-> img_valid)
    else $error("line strobe without a pixel");
  a_height_one: assert property (@(posedge clk) disable iff (reset)
    image_height == IMAGE_HEIGHT)
    else $error("image height not one line");
endmodule : lrb_line_roi

// >>> lrb_host_model.sv
// grabber side capture of the line image stream
`timescale 1ns/10ps
module lrb_host_model
  import lrb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // image stream
  input wire logic img_valid,
  input wire logic [PIX_W-1:0] img_data,
  input wire logic img_line_start,
  input wire logic img_line_end
);
  logic [PIX_W-1:0] got[$];
  int n_start = 0;
  int first_at = -1;
  int last_at = -1;
  // no back-pressure: the grabber must take every pixel as it comes
  always @(posedge clk) begin
    if (!reset && img_valid) begin
      if (img_line_start) begin
        n_start++;
        first_at = got.size();
      end
      if (img_line_end) begin
        last_at = got.size();
      end
      got.push_back(img_data);
    end
  end
  task automatic clear();
    got.delete();
    n_start = 0;
    first_at = -1;
    last_at = -1;
  endtask : clear
endmodule : lrb_host_model

// >>> lrb_line_roi_tb.sv
// self-checking bench for the line crop and merge stage
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module lrb_line_roi_tb
  import lrb_pkg::*;
;
  logic clk = 0;
  logic reset = 1;
  logic cfg_write = 0;
  logic [CNT_W-1:0] cfg_width = '0;
  logic [CNT_W-1:0] horizontal_start_offset = '0;
  logic horizontal_pixel_merge = 0;
  logic merge_average = 0;
  logic [1:0] sample_format_select = '0;
  logic external_trigger_enable = 0;
  logic line_rate_speed_option = 0;
  logic capture_begin_cmd = 0;
  logic capture_halt_cmd = 0;
  logic capture_end_cmd = 0;
  logic acq_trigger_pin = 0;
  logic sensor_line_start = 0;
  logic sensor_valid = 0;
  logic [PIX_W-1:0] sensor_pix = '0;
  logic img_valid, img_line_start, img_line_end, cfg_rejected, capturing;
  logic [PIX_W-1:0] img_data;
  logic [CNT_W-1:0] active_width, active_offset, image_height, min_line_clocks;
  int error_cnt = 0;
  int n_tests = 0;
  int cur_w, cur_o;
  bit cur_m, cur_a;
  logic [1:0] cur_f;
  always #50 clk = ~clk;
  lrb_line_roi DUT (.clk, .reset, .cfg_write, .cfg_width,
    .horizontal_start_offset, .horizontal_pixel_merge, .merge_average,
    .sample_format_select, .external_trigger_enable, .line_rate_speed_option,
    .capture_begin_cmd, .capture_halt_cmd, .capture_end_cmd, .acq_trigger_pin,
    .sensor_line_start, .sensor_valid, .sensor_pix, .img_valid, .img_data,
    .img_line_start, .img_line_end, .active_width, .active_offset,
    .image_height, .cfg_rejected, .capturing, .min_line_clocks);
  lrb_host_model host (.clk, .reset, .img_valid, .img_data, .img_line_start,
    .img_line_end);
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask : step
  // reset is the cheap way to end a line early so settings may be written
  task automatic restart(int n);
    reset = 1;
    step(n);
    reset = 0;
    host.clear();
    cur_w = RST_WIDTH;
    cur_o = 0;
    cur_m = 0;
    cur_a = 0;
    cur_f = FMT_RST;
  endtask : restart
  task automatic cmd(int k);
    capture_begin_cmd = (k == 0);
    capture_halt_cmd = (k == 1);
    capture_end_cmd = (k == 2);
    step(1);
    {capture_begin_cmd, capture_halt_cmd, capture_end_cmd} = 3'h0;
    step(2);
  endtask : cmd
  // pin passes a synchroniser, so hold it well past the capture latency
  task automatic trig();
    acq_trigger_pin = 1;
    step(6);
    acq_trigger_pin = 0;
    step(2);
  endtask : trig
  function automatic bit legal(int w, int o, bit m);
    int s = m ? 64 : 128;
    return w >= s && w % s == 0 && o % s == 0 && w + o <= s * 128;
  endfunction : legal
  task automatic write_cfg(int w, int o, bit m, bit a, logic [1:0] f);
    bit ok;
    ok = legal(w, o, m);
    cfg_width = w[CNT_W-1:0];
    horizontal_start_offset = o[CNT_W-1:0];
    horizontal_pixel_merge = m;
    merge_average = a;
    sample_format_select = f;
    cfg_write = 1;
    step(1);
    cfg_write = 0;
    step(1);
    if (ok) begin
      cur_w = w;
      cur_o = o;
      cur_m = m;
    end
    cur_a = a;
    if (f != 2'h3) cur_f = f;
    `CHK("rejected", !ok, cfg_rejected)
    `CHK("width", cur_w[CNT_W-1:0], active_width)
    `CHK("offset", cur_o[CNT_W-1:0], active_offset)
  endtask : write_cfg
  function automatic logic [PIX_W-1:0] exp_px(logic [PIX_W-1:0] a,
    logic [PIX_W-1:0] b);
    logic [PIX_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (cur_m) a = cur_a ? s[PIX_W:1] : (s[PIX_W] ? 12'hFFF : s[PIX_W-1:0]);
    return cur_f == 2'h0 ? a >> 4 : cur_f == 2'h1 ? a >> 2 : a;
  endfunction : exp_px
  function automatic logic [CNT_W-1:0] exp_mlc();
    int c = cur_w * (cur_f == 2'h0 ? BYTE_PER_PIX_8 : BYTE_PER_PIX_HI);
    int fl = line_rate_speed_option ? FAST_MIN_CLK : NORMAL_MIN_CLK;
    int top = (1 << CNT_W) - 1;
    return CNT_W'(c > top ? top : c < fl ? fl : c);
  endfunction : exp_mlc
  task automatic run_line(int n, bit on, bit hi = 0);
    logic [PIX_W-1:0] px[$];
    logic [PIX_W-1:0] e[$];
    int j;
    sensor_line_start = 1;
    step(1);
    sensor_line_start = 0;
    repeat (n) begin
      sensor_valid = 1;
      sensor_pix = hi ? 12'hE00 | PIX_W'($urandom) : PIX_W'($urandom);
      px.push_back(sensor_pix);
      step(1);
    end
    sensor_valid = 0;
    step(4);
    if (on) for (int u = cur_o; u < cur_o + cur_w; u++) begin
      j = cur_m ? 2 * u : u;
      e.push_back(exp_px(px[j], px[j + 1]));
    end
    `CHK("pixels", e.size(), host.got.size())
    foreach (e[i]) `CHK("pixel", e[i], host.got[i])
    `CHK("starts", int'(on), host.n_start)
    if (on) begin
      `CHK("first", 0, host.first_at)
      `CHK("last", e.size() - 1, host.last_at)
    end
    host.clear();
  endtask : run_line
  task automatic done(string t);
    $display("test %s done, checks %0d", t, n_tests);
  endtask : done
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // about 55k cycles expected; allow 80k
  initial begin
    #(80000 * 100);
    error_cnt++;
    $display("[FAIL] watchdog exp finish got hang");
    report_and_stop();
  end
  initial begin
    int o;
    int w;
    void'($urandom(52));
    restart(4);
    `CHK("height", IMAGE_HEIGHT, image_height)
    `CHK("capturing", 1'b0, capturing)
    cmd(0);
    `CHK("capturing", 1'b1, capturing)
    run_line(16386, 1);
    done("default line");
    for (int f = 0; f < 3; f++) begin
      restart(2);
      w = f == 2 ? 128 : 128 * (1 + $urandom % 4);
      o = f == 0 ? 128 : f == 1 ? 128 * ($urandom % 64) : 16384 - w;
      write_cfg(w, o, 0, 0, f[1:0]);
      cmd(0);
      run_line(o + w + 2, 1);
      done("crop");
    end
    for (int a = 0; a < 2; a++) begin
      restart(2);
      line_rate_speed_option = a[0];
      w = 64 * (1 + $urandom % 2);
      o = a ? 8192 - w : 64 * ($urandom % 4);
      write_cfg(w, o, 1, a[0], 2'($urandom % 3));
      step(2);
      `CHK("min clocks", exp_mlc(), min_line_clocks)
      cmd(0);
      run_line(2 * (o + w) + 2, 1, !a);
      done("merge");
    end
    restart(2);
    write_cfg(256, 128, 0, 0, 2'h1);
    write_cfg(100, 0, 0, 1, 2'h3);
    write_cfg(256, 64, 0, 0, 2'h3);
    write_cfg(256, 16256, 0, 0, 2'h3);
    write_cfg(0, 0, 0, 0, 2'h3);
    write_cfg(64, 8192, 1, 0, 2'h3);
    write_cfg(96, 0, 1, 0, 2'h3);
    cmd(0);
    run_line(400, 1);
    done("refused");
    restart(2);
    external_trigger_enable = 1;
    write_cfg(128, 0, 0, 0, 2'h2);
    cmd(0);
    `CHK("armed", 1'b0, capturing)
    run_line(130, 0);
    trig();
    `CHK("triggered", 1'b1, capturing)
    run_line(130, 1);
    cmd(2);
    trig();
    `CHK("ended", 1'b0, capturing)
    run_line(130, 0);
    cmd(0);
    trig();
    cmd(1);
    `CHK("halted", 1'b0, capturing)
    done("trigger");
    report_and_stop();
  end
endmodule : lrb_line_roi_tb
